// ---- common/srb_pkg.sv ----
// shared constants for the serial radio bridge control block
package srb_pkg;
    localparam int CLK_HZ = 100000000;
    localparam int BLINK_FAST_MS = 1000;
    localparam int BLINK_SLOW_MS = 3000;
    localparam int BLINK_FAST_CYC = CLK_HZ / 1000 * BLINK_FAST_MS;
    localparam int BLINK_SLOW_CYC = CLK_HZ / 1000 * BLINK_SLOW_MS;
    localparam int LAMP_PULSE_MS = 50;
    localparam int LAMP_PULSE_CYC = CLK_HZ / 1000 * LAMP_PULSE_MS;
    localparam int ADDR_DIGITS = 12;
    localparam int ADDR_W = ADDR_DIGITS * 4;
    localparam int DATA_BITS = 8;
    localparam int BUF_DEPTH = 64;
    localparam int BUF_AW = 6;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SERIAL = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_ADDR_LO = 8'h0C;
    localparam logic [7:0] REG_ADDR_HI = 8'h10;
    localparam logic [7:0] REG_LINK_TX = 8'h14;
    localparam logic [7:0] REG_LINK_CMD = 8'h18;
    localparam logic [7:0] REG_RX_DATA = 8'h1C;
    // ctrl fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SWRST_BIT = 4;
    localparam int CTRL_CLEAR_ADDR_BIT = 5;
    // serial fields
    localparam int SER_BAUD_LSB = 0;
    localparam int SER_PAR_LSB = 4;
    localparam int SER_STOP2_BIT = 6;
    // link command bits
    localparam int CMD_CONNECTED_BIT = 0;
    localparam int CMD_DISCONNECT_BIT = 1;
    localparam int CMD_PKT_DONE_BIT = 2;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [3:0] BAUD_RESET = 4'h3;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam int PKT_MAX = 16;
    typedef enum logic [1:0] {
        SRB_IDLE_CONFIG_MODE = 2'h0,
        SRB_AUTO_INITIATE_MODE = 2'h1,
        SRB_WAIT_LAST_PEER_MODE = 2'h2,
        SRB_OPEN_ACCEPT_MODE = 2'h3
    } srb_mode_t;
    // bit period in clock cycles for each baud code
    function automatic logic [16:0] srb_baud_div(input logic [3:0] code);
        case (code)
            4'h0: srb_baud_div = 17'(CLK_HZ / 1200);
            4'h1: srb_baud_div = 17'(CLK_HZ / 2400);
            4'h2: srb_baud_div = 17'(CLK_HZ / 4800);
            4'h3: srb_baud_div = 17'(CLK_HZ / 9600);
            4'h4: srb_baud_div = 17'(CLK_HZ / 19200);
            4'h5: srb_baud_div = 17'(CLK_HZ / 38200);
            4'h6: srb_baud_div = 17'(CLK_HZ / 57600);
            4'h7: srb_baud_div = 17'(CLK_HZ / 115200);
            4'h8: srb_baud_div = 17'(CLK_HZ / 230400);
            default: srb_baud_div = 17'(CLK_HZ / 9600);
        endcase
    endfunction
endpackage

// ---- rtl/srb_buf_mem.sv ----
// host data buffer memory with registered read
`timescale 1ns/100ps
`default_nettype none
module srb_buf_mem #(
    parameter int WIDTH = 8,
    parameter int AW = 6
) (
    input wire logic pclk, // clock
    input wire logic wr_en, // write strobe
    input wire logic [AW-1:0] wr_addr, // write address
    input wire logic [WIDTH-1:0] wr_data, // write data
    input wire logic [AW-1:0] rd_addr, // read address
    output logic [WIDTH-1:0] rd_data // registered read data
);
    logic [WIDTH-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// ---- rtl/srb_lamp_pulse.sv ----
// stretches a one-cycle event into a visible lamp pulse
`timescale 1ns/100ps
`default_nettype none
module srb_lamp_pulse #(
    parameter int PULSE_CYC = 5000000
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic trig, // one-cycle event
    output logic lamp // stretched lamp drive
);
    logic [31:0] cnt;
    initial begin
        if (PULSE_CYC < 1) $error("pulse length must be at least one cycle");
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 32'h0;
            lamp <= 1'b0;
        end else begin
            if (trig) begin
                cnt <= 32'(PULSE_CYC - 1);
                lamp <= 1'b1;
            end else if (cnt != 32'h0) begin
                cnt <= cnt - 32'h1;
            end else begin
                lamp <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/srb_bridge_ctrl.sv ----
// serial-side control of the wireless serial bridge: uart, buffer, modes, lamps, apb
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RULE_01: idle mode: silent serial port, await host
// RULE_02: idle mode: no link role, config writable
// RULE_03: always keep twelve-digit last peer address
// RULE_04: hard reset clears stored peer address
// RULE_05: auto-initiate: initiate to last peer on reset
// RULE_06: auto-initiate: hidden, refuse incoming links
// RULE_07: wait mode: accept only last peer, hidden
// RULE_08: open-accept: discoverable, accept any peer
// RULE_09: lamps: red idle, blink 1s/3s, solid connected
// RULE_10: activity lamps pulse on serial traffic
// RULE_11: nine selectable baud rates
// RULE_12: eight data bits per character only
// RULE_13: parity none/even/odd, one or two stops
// RULE_14: host maps 7-bit parity to 8N
// RULE_15: flow control set only by switch pin
// RULE_16: buffer host data, resend packets until delivered
// RULE_17: flow control: drop rts when buffer full
// RULE_18: flow control: raise rts when space frees
// RULE_19: host holds characters while rts dropped
// RULE_20: no flow control: flush buffer when full
// RULE_21: host advised to use flow control
module srb_bridge_ctrl #(
    parameter int BLINK_FAST = srb_pkg::BLINK_FAST_CYC,
    parameter int BLINK_SLOW = srb_pkg::BLINK_SLOW_CYC,
    parameter int LAMP_PULSE = srb_pkg::LAMP_PULSE_CYC,
    parameter int BUF_AW = srb_pkg::BUF_AW,
    parameter int PKT_MAX = srb_pkg::PKT_MAX
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic ser_rxd, // serial data from host
    output logic ser_txd, // serial data to host
    output logic ser_rts, // request to send toward host, high = may send
    input wire logic flow_switch, // flow control switch pin
    output logic link_initiate, // initiate connection to stored peer
    output logic link_accept, // accept incoming connections
    output logic link_discoverable, // answer radio inquiries
    output logic link_last_only, // accept only the stored peer
    output logic [47:0] peer_radio_address, // stored last peer address
    output logic peer_valid, // stored address present
    output logic pkt_valid, // packet byte offered to radio
    output logic [7:0] pkt_data, // packet byte
    input wire logic pkt_ready, // radio took packet byte
    output logic standby_lamp, // red standby lamp
    output logic connect_lamp, // green connect lamp
    output logic tx_activity_lamp, // host to device traffic
    output logic rx_activity_lamp // device to host traffic
);
    localparam int DEPTH = 1 << BUF_AW;
    initial begin
        if (BUF_AW < 2 || BUF_AW > 12) $error("buffer address width out of range");
        if (PKT_MAX < 1 || PKT_MAX >= DEPTH) $error("packet size must be below buffer depth");
        if (BLINK_FAST < 2 || BLINK_SLOW < 2) $error("blink periods too short");
    end

    // synchronisers
    logic rxd_s1, rxd_s2, flow_s1, flow_s2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
            flow_s1 <= 1'b0;
            flow_s2 <= 1'b0;
        end else begin
            rxd_s1 <= ser_rxd;
            rxd_s2 <= rxd_s1;
            flow_s1 <= flow_switch;
            flow_s2 <= flow_s1;
        end
    end
    logic flow_en;
    assign flow_en = flow_s2; // RULE_15

    // configuration registers
    srb_pkg::srb_mode_t mode;
    logic [3:0] baud_code;
    logic [1:0] parity;
    logic stop2;
    logic connected;
    logic swrst;
    logic [31:0] status_word;
    logic apb_wr, apb_rd;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    logic addr_ok;
    // all eight words sit aligned in the first 32 bytes
    assign addr_ok = paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;
    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= srb_pkg::SRB_IDLE_CONFIG_MODE; // RULE_02
            baud_code <= srb_pkg::BAUD_RESET;
            parity <= srb_pkg::PAR_NONE;
            stop2 <= 1'b0;
            swrst <= 1'b0;
        end else begin
            swrst <= apb_wr && paddr == srb_pkg::REG_CTRL && pwdata[srb_pkg::CTRL_SWRST_BIT];
            if (apb_wr && paddr == srb_pkg::REG_CTRL) begin
                mode <= srb_pkg::srb_mode_t'(pwdata[srb_pkg::CTRL_MODE_LSB +: 2]);
            end
            // serial settings change only while idle and unconnected
            if (apb_wr && paddr == srb_pkg::REG_SERIAL && mode == srb_pkg::SRB_IDLE_CONFIG_MODE
                && !connected) begin // RULE_02
                baud_code <= (pwdata[3:0] > 4'h8) ? srb_pkg::BAUD_RESET : pwdata[3:0]; // RULE_11
                parity <= (pwdata[5:4] == 2'h3) ? srb_pkg::PAR_NONE : pwdata[5:4]; // RULE_13
                stop2 <= pwdata[srb_pkg::SER_STOP2_BIT]; // RULE_13
            end
        end
    end

    // peer address and link state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peer_radio_address <= 48'h0; // RULE_04
            peer_valid <= 1'b0; // RULE_04
            connected <= 1'b0;
        end else begin
            if (apb_wr && paddr == srb_pkg::REG_ADDR_LO) begin
                peer_radio_address[31:0] <= pwdata; // RULE_03
            end
            if (apb_wr && paddr == srb_pkg::REG_ADDR_HI) begin
                peer_radio_address[47:32] <= pwdata[15:0]; // RULE_03
            end
            if (apb_wr && paddr == srb_pkg::REG_LINK_CMD && pwdata[srb_pkg::CMD_CONNECTED_BIT]) begin
                connected <= 1'b1;
                peer_valid <= 1'b1; // RULE_03
            end else if (swrst || (apb_wr && paddr == srb_pkg::REG_LINK_CMD
                && pwdata[srb_pkg::CMD_DISCONNECT_BIT])) begin
                connected <= 1'b0;
            end
            if (apb_wr && paddr == srb_pkg::REG_CTRL && pwdata[srb_pkg::CTRL_CLEAR_ADDR_BIT]) begin
                peer_valid <= 1'b0;
            end
        end
    end

    // link role outputs; last-peer modes need a stored address
    always_comb begin
        link_initiate = 1'b0;
        link_accept = 1'b0;
        link_discoverable = 1'b0;
        link_last_only = 1'b0;
        if (!connected) begin
            case (mode)
                srb_pkg::SRB_IDLE_CONFIG_MODE: link_initiate = 1'b0; // RULE_02
                srb_pkg::SRB_AUTO_INITIATE_MODE: link_initiate = peer_valid; // RULE_05 RULE_06
                srb_pkg::SRB_WAIT_LAST_PEER_MODE: begin
                    link_accept = peer_valid; // RULE_07
                    link_last_only = 1'b1; // RULE_07
                end
                srb_pkg::SRB_OPEN_ACCEPT_MODE: begin
                    link_accept = 1'b1; // RULE_08
                    link_discoverable = 1'b1; // RULE_08
                end
                default: link_initiate = 1'b0;
            endcase
        end
    end

    // host receiver, 8 data bits with optional parity and stops
    logic [16:0] bit_div;
    assign bit_div = srb_pkg::srb_baud_div(baud_code);
    logic [16:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [8:0] rx_sh;
    logic rx_busy, rx_done;
    logic [3:0] rx_nbits;
    assign rx_nbits = (parity == srb_pkg::PAR_NONE) ? 4'h8 : 4'h9; // RULE_12
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt <= 17'h0;
            rx_bit <= 4'h0;
            rx_sh <= 9'h0;
            rx_busy <= 1'b0;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (!rx_busy) begin
                if (!rxd_s2) begin
                    rx_busy <= 1'b1;
                    rx_cnt <= {1'b0, bit_div[16:1]};
                    rx_bit <= 4'h0;
                end
            end else if (rx_cnt != 17'h0) begin
                rx_cnt <= rx_cnt - 17'h1;
            end else begin
                rx_cnt <= bit_div - 17'h1;
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0 && rxd_s2) begin
                    rx_busy <= 1'b0;
                end else if (rx_bit == rx_nbits + 4'h1) begin
                    rx_busy <= 1'b0;
                    rx_done <= rxd_s2;
                end else if (rx_bit != 4'h0) begin
                    rx_sh <= {rxd_s2, rx_sh[8:1]};
                end
            end
        end
    end
    logic [7:0] rx_byte;
    assign rx_byte = (parity == srb_pkg::PAR_NONE) ? rx_sh[8:1] : rx_sh[7:0];

    // transmit buffer toward the radio
    logic [BUF_AW:0] wr_ptr, rd_ptr, pkt_ptr;
    logic [BUF_AW:0] used;
    logic buf_full, buf_push, flush;
    assign used = wr_ptr - rd_ptr;
    assign buf_full = used == (BUF_AW + 1)'(DEPTH);
    assign flush = !flow_en && buf_full && rx_done; // RULE_20
    assign buf_push = rx_done && (!buf_full || flush); // RULE_16
    logic rd_valid;
    logic [BUF_AW:0] pkt_len;
    logic [7:0] mem_q;
    srb_buf_mem #(.WIDTH(8), .AW(BUF_AW)) u_mem (
        .pclk(pclk),
        .wr_en(buf_push),
        .wr_addr(flush ? rd_ptr[BUF_AW-1:0] : wr_ptr[BUF_AW-1:0]),
        .wr_data(rx_byte),
        .rd_addr(pkt_ptr[BUF_AW-1:0]),
        .rd_data(mem_q)
    );
    assign pkt_data = mem_q;
    // packet bytes are freed only on delivery or by a flush; a failed packet is resent from its start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            pkt_ptr <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            if (flush) begin
                wr_ptr <= rd_ptr + (BUF_AW + 1)'(1);
                pkt_ptr <= rd_ptr;
            end else begin
                if (buf_push) begin
                    wr_ptr <= wr_ptr + (BUF_AW + 1)'(1);
                end
                if (apb_wr && paddr == srb_pkg::REG_LINK_CMD && pwdata[srb_pkg::CMD_PKT_DONE_BIT]) begin
                    rd_ptr <= pkt_ptr; // RULE_16
                end else if (!connected) begin
                    pkt_ptr <= rd_ptr; // RULE_16
                end else if (pkt_valid && pkt_ready) begin
                    pkt_ptr <= pkt_ptr + (BUF_AW + 1)'(1);
                end else if (!pkt_valid && !rd_valid && pkt_ptr != wr_ptr && pkt_len < (BUF_AW + 1)'(PKT_MAX)) begin
                    rd_valid <= 1'b1;
                end
            end
        end
    end
    assign pkt_len = pkt_ptr - rd_ptr;
    logic pkt_hold;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_hold <= 1'b0;
        end else if (flush || !connected || (pkt_valid && pkt_ready)) begin
            pkt_hold <= 1'b0;
        end else if (rd_valid) begin
            pkt_hold <= 1'b1;
        end
    end
    assign pkt_valid = pkt_hold;
    assign ser_rts = flow_en ? !buf_full : 1'b1; // RULE_17 RULE_18 RULE_19

    // host transmitter: sends bytes written by link side, never unsolicited
    logic [16:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [11:0] tx_sh;
    logic tx_busy, tx_start;
    logic [3:0] tx_total;
    logic par_bit;
    assign tx_start = apb_wr && paddr == srb_pkg::REG_LINK_TX && !tx_busy; // RULE_01
    assign par_bit = ^pwdata[7:0] ^ (parity == srb_pkg::PAR_ODD);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt <= 17'h0;
            tx_bit <= 4'h0;
            tx_sh <= 12'hFFF;
            tx_busy <= 1'b0;
            tx_total <= 4'h0;
        end else if (tx_start) begin
            tx_busy <= 1'b1;
            tx_cnt <= bit_div - 17'h1;
            tx_bit <= 4'h0;
            tx_total <= 4'd10 + {3'h0, parity != srb_pkg::PAR_NONE} + {3'h0, stop2}; // RULE_13
            tx_sh <= (parity == srb_pkg::PAR_NONE) ? {3'h7, pwdata[7:0], 1'b0}
                : {2'h3, par_bit, pwdata[7:0], 1'b0}; // RULE_12
        end else if (tx_busy) begin
            if (tx_cnt != 17'h0) begin
                tx_cnt <= tx_cnt - 17'h1;
            end else begin
                tx_cnt <= bit_div - 17'h1;
                tx_sh <= {1'b1, tx_sh[11:1]};
                tx_bit <= tx_bit + 4'h1;
                if (tx_bit == tx_total - 4'h1) begin
                    tx_busy <= 1'b0;
                end
            end
        end
    end
    assign ser_txd = tx_sh[0];

    // status and read data
    assign status_word = {24'h0, rx_busy, flow_en, buf_full, tx_busy, connected, peer_valid, mode};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                srb_pkg::REG_CTRL: prdata <= {30'h0, mode};
                srb_pkg::REG_SERIAL: prdata <= {25'h0, stop2, parity, baud_code};
                srb_pkg::REG_STATUS: prdata <= status_word;
                srb_pkg::REG_ADDR_LO: prdata <= peer_radio_address[31:0];
                srb_pkg::REG_ADDR_HI: prdata <= {16'h0, peer_radio_address[47:32]};
                srb_pkg::REG_RX_DATA: prdata <= {{(31-BUF_AW){1'b0}}, used};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // lamps
    logic [31:0] blink_cnt;
    logic blink;
    logic [31:0] blink_per;
    assign blink_per = (mode == srb_pkg::SRB_AUTO_INITIATE_MODE) ? 32'(BLINK_FAST) : 32'(BLINK_SLOW);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt <= 32'h0;
            blink <= 1'b0;
        end else if (blink_cnt >= blink_per - 32'h1) begin
            blink_cnt <= 32'h0;
            blink <= 1'b1;
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
            blink <= 1'b0;
        end
    end
    logic blink_lamp;
    srb_lamp_pulse #(.PULSE_CYC(LAMP_PULSE)) u_blink (
        .pclk(pclk), .presetn(presetn), .trig(blink), .lamp(blink_lamp));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_lamp <= 1'b0;
            connect_lamp <= 1'b0;
        end else begin
            standby_lamp <= mode == srb_pkg::SRB_IDLE_CONFIG_MODE && !connected; // RULE_09
            connect_lamp <= connected || (mode != srb_pkg::SRB_IDLE_CONFIG_MODE && blink_lamp); // RULE_09
        end
    end
    srb_lamp_pulse #(.PULSE_CYC(LAMP_PULSE)) u_txl (
        .pclk(pclk), .presetn(presetn), .trig(rx_done), .lamp(tx_activity_lamp)); // RULE_10
    srb_lamp_pulse #(.PULSE_CYC(LAMP_PULSE)) u_rxl (
        .pclk(pclk), .presetn(presetn), .trig(tx_start), .lamp(rx_activity_lamp)); // RULE_10
endmodule
`default_nettype wire

// ---- bench/srb_bridge_ctrl_properties.sv ----
// assertion checker for the serial radio bridge control block
`timescale 1ns/100ps
`default_nettype none
module srb_bridge_ctrl_properties (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic flow_switch, // flow control switch
    input wire logic ser_rts, // rts toward host
    input wire logic link_initiate, // initiating role
    input wire logic link_accept, // accepting role
    input wire logic link_discoverable, // visible to inquiries
    input wire logic link_last_only, // stored peer only
    input wire logic peer_valid, // stored address present
    input wire logic tx_activity_lamp // host traffic lamp
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_no_peer; $rose(presetn) |-> !peer_valid; endproperty
    a_no_peer: assert property (p_no_peer) else $error("peer held after reset");
    property p_init_peer; link_initiate |-> peer_valid; endproperty
    a_init_peer: assert property (p_init_peer) else $error("initiate without peer");
    property p_init_hidden; link_initiate |-> !link_accept && !link_discoverable; endproperty
    a_init_hidden: assert property (p_init_hidden) else $error("initiator visible");
    property p_last; link_last_only |-> link_accept && peer_valid && !link_discoverable; endproperty
    a_last: assert property (p_last) else $error("last peer wait wrong");
    property p_open; link_discoverable |-> link_accept && !link_last_only; endproperty
    a_open: assert property (p_open) else $error("open accept wrong");
    property p_flow_off; !flow_switch [*5] |-> ser_rts; endproperty
    a_flow_off: assert property (p_flow_off) else $error("rts low without flow");
    property p_rts_drop; $fell(ser_rts) |-> flow_switch; endproperty
    a_rts_drop: assert property (p_rts_drop) else $error("rts drop unexpected");
    property p_lamp; $rose(tx_activity_lamp) |-> tx_activity_lamp [*4] ##1 !tx_activity_lamp; endproperty
    a_lamp: assert property (p_lamp) else $error("activity pulse length");
    c_init: cover property (link_initiate);
    c_open: cover property (link_discoverable);
    c_rts: cover property (!ser_rts);
endmodule
bind srb_bridge_ctrl srb_bridge_ctrl_properties u_props (.pclk(pclk), .presetn(presetn),
    .flow_switch(flow_switch), .ser_rts(ser_rts), .link_initiate(link_initiate), .link_accept(link_accept),
    .link_discoverable(link_discoverable), .link_last_only(link_last_only), .peer_valid(peer_valid),
    .tx_activity_lamp(tx_activity_lamp));
`default_nettype wire

// ---- bench/srb_host_model.sv ----
// host serial device sending 8N1 characters
`timescale 1ns/100ps
`default_nettype none
module srb_host_model #(
    parameter int BIT_CYC = 434
) (
    input wire logic pclk, // clock
    input wire logic ser_rts, // device may-send level
    input wire logic send, // request one character
    input wire logic [7:0] data, // character to send
    output logic busy, // frame in progress
    output logic ser_rxd // line toward device
);
    logic [9:0] frame;
    int n;
    initial begin
        ser_rxd = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge pclk);
            if (send && ser_rts) begin
                busy <= 1'b1;
                frame = {1'b1, data, 1'b0};
                for (n = 0; n < 10 * BIT_CYC; n++) begin
                    ser_rxd <= frame[n / BIT_CYC];
                    @(posedge pclk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the serial radio bridge control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int BIT_CYC = 434;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic flow_switch = 1'b0, pkt_ready = 1'b0, send = 1'b0, lamp_seen = 1'b0;
    logic [7:0] paddr = 8'h00, hdata = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic [31:0] prdata;
    logic [47:0] peer_radio_address;
    logic [7:0] pkt_data;
    logic pready, pslverr, ser_rxd, ser_txd, ser_rts, link_initiate, link_accept, link_discoverable;
    logic link_last_only, peer_valid, pkt_valid, standby_lamp, connect_lamp, tx_activity_lamp;
    logic rx_activity_lamp, hbusy, slverr;
    logic [5:0] rows [4] = '{6'h00, 6'h18, 6'h25, 6'h36};
    int err_total = 0, n_checks = 0, k;
    srb_bridge_ctrl #(.BLINK_FAST(40), .BLINK_SLOW(120), .LAMP_PULSE(4), .BUF_AW(2), .PKT_MAX(2)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ser_rxd(ser_rxd),
        .ser_txd(ser_txd), .ser_rts(ser_rts), .flow_switch(flow_switch), .link_initiate(link_initiate),
        .link_accept(link_accept), .link_discoverable(link_discoverable), .link_last_only(link_last_only),
        .peer_radio_address(peer_radio_address), .peer_valid(peer_valid), .pkt_valid(pkt_valid),
        .pkt_data(pkt_data), .pkt_ready(pkt_ready), .standby_lamp(standby_lamp), .connect_lamp(connect_lamp),
        .tx_activity_lamp(tx_activity_lamp), .rx_activity_lamp(rx_activity_lamp));
    srb_host_model #(.BIT_CYC(BIT_CYC)) u_host (.pclk(pclk), .ser_rts(ser_rts), .send(send), .data(hdata),
        .busy(hbusy), .ser_rxd(ser_rxd));
    always #5 pclk = ~pclk;
    always @(posedge pclk) if (tx_activity_lamp === 1'b1) lamp_seen <= 1'b1;
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int lim);
        if (k > lim) begin
            err_total++;
            test_done();
        end
        @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k == 0 || pready !== 1'b1; k++) tick(20);
        rd = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic host_tx(input logic [7:0] b);
        hdata <= b;
        send <= 1'b1;
        for (k = 0; hbusy !== 1'b1; k++) tick(100);
        send <= 1'b0;
        for (k = 0; hbusy !== 1'b0; k++) tick(12 * BIT_CYC);
        repeat (2 * BIT_CYC) @(posedge pclk);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(peer_valid, 0);
        chk(ser_txd, 1);
        apb(0, srb_pkg::REG_STATUS, 0);
        chk(rd, 0);
        apb(0, srb_pkg::REG_SERIAL, 0);
        chk(rd, 32'h3);
        apb(0, 8'h40, 0);
        chk({slverr, rd}, {1'b1, 32'h0});
        apb(1, srb_pkg::REG_CTRL, 32'h1);
        chk(link_initiate, 0);
        apb(1, srb_pkg::REG_CTRL, 32'h0);
        for (int i = 0; i < 9; i++) begin
            apb(1, srb_pkg::REG_SERIAL, i | ((i % 3) << 4) | ((i & 1) << 6));
            apb(0, srb_pkg::REG_SERIAL, 0);
            chk(rd, i | ((i % 3) << 4) | ((i & 1) << 6));
        end
        apb(1, srb_pkg::REG_SERIAL, 32'h8);
        for (int i = 0; i < 5; i++) host_tx(8'h50 + 8'(i));
        apb(0, srb_pkg::REG_RX_DATA, 0);
        chk(rd, 1);
        chk(lamp_seen, 1);
        flow_switch <= 1'b1;
        for (int i = 5; i < 8; i++) host_tx(8'h50 + 8'(i));
        apb(0, srb_pkg::REG_STATUS, 0);
        chk(rd[6:5], 2'h3);
        chk(ser_rts, 0);
        apb(1, srb_pkg::REG_ADDR_LO, 32'hC3D4E5F6);
        apb(1, srb_pkg::REG_ADDR_HI, 32'hA1B2);
        apb(1, srb_pkg::REG_LINK_CMD, 32'h1);
        chk(peer_radio_address, 48'hA1B2C3D4E5F6);
        pkt_ready <= 1'b1;
        for (k = 0; pkt_valid !== 1'b1; k++) tick(50);
        chk(pkt_data, 8'h54);
        chk(connect_lamp, 1);
        apb(1, srb_pkg::REG_LINK_CMD, 32'h4);
        for (k = 0; ser_rts !== 1'b1; k++) tick(50);
        chk(ser_rts, 1);
        apb(1, srb_pkg::REG_LINK_CMD, 32'h2);
        foreach (rows[i]) begin
            apb(1, srb_pkg::REG_CTRL, {30'h0, rows[i][5:4]});
            apb(0, srb_pkg::REG_STATUS, 0);
            chk(rd[1:0], rows[i][5:4]);
            chk({link_initiate, link_accept, link_discoverable, link_last_only}, rows[i][3:0]);
            chk(standby_lamp, rows[i][5:4] == 2'h0);
        end
        apb(1, srb_pkg::REG_LINK_TX, 32'hA5);
        chk({ser_txd, rx_activity_lamp}, 2'h1);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(peer_valid, 0);
        test_done();
    end
endmodule
`default_nettype wire
